// *** hw/ffdd_pkg.sv ***
// shared constants, carrier types and state enumerations of the filter demo datapath
package ffdd_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int WORD_W              = 16;
	localparam int BYTE_W              = 8;
	localparam int TAPS_DEFAULT        = 127;
	localparam int POINTS_DEFAULT      = 256;
	localparam int TXBUF_DEPTH_DEFAULT = 2;

	// ----------------------------------------------------------------
	// link characters
	// ----------------------------------------------------------------
	localparam logic [BYTE_W-1:0] CHAR_SYNC  = 8'h39;
	localparam logic [BYTE_W-1:0] CHAR_ACK   = 8'h46;
	localparam logic [BYTE_W-1:0] CHAR_HAND  = 8'h68;
	localparam logic [BYTE_W-1:0] CHAR_AGREE = 8'h61;
	localparam logic [BYTE_W-1:0] CHAR_READY = 8'h72;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] RST_PIPE_INIT = 2'h0;

	// ----------------------------------------------------------------
	// carriers and states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              valid;
		logic              first;
		logic [WORD_W-1:0] data;
	} ffdd_word_type;

	typedef struct packed {
		logic              valid;
		logic [WORD_W-1:0] re;
		logic [WORD_W-1:0] im;
	} ffdd_spec_type;

	typedef enum logic [3:0] {
		LINK_WAIT_SYNC, LINK_SEND_ACK, LINK_SEND_HAND, LINK_SEND_AGREE,
		LINK_RX_COEF, LINK_SEND_READY, LINK_RX_SAMP, LINK_RUN,
		LINK_TX_FIR, LINK_TX_RE, LINK_TX_IM
	} ffdd_link_type;

	typedef enum logic [1:0] {
		SEQ_IDLE, SEQ_COEF, SEQ_DATA, SEQ_DRAIN
	} ffdd_seq_type;

endpackage

// *** hw/ffdd_tx_buffer.sv ***
// small valid/ready buffer in front of the serial transmitter
`timescale 1ns/10ps
`default_nettype none
module ffdd_tx_buffer
	import ffdd_pkg::*;
#(
	parameter int WIDTH = BYTE_W,
	parameter int DEPTH = TXBUF_DEPTH_DEFAULT
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
			end
			cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
		end
	end

	chk_no_overfill: assert property (@(posedge clock) disable iff (!rst_n)
		cnt_q <= CW'(DEPTH)) else $error("tx buffer count above depth");

endmodule
`default_nettype wire

// *** hw/ffdd_datapath.sv ***
// host link, buffers and filter sequencer of the filter demo datapath
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module ffdd_datapath
	import ffdd_pkg::*;
#(
	parameter int TAPS        = TAPS_DEFAULT,
	parameter int POINTS      = POINTS_DEFAULT,
	parameter int TXBUF_DEPTH = TXBUF_DEPTH_DEFAULT
) (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                ce,
	input  wire logic                init_done,
	input  wire logic                pll_locked,
	input  wire logic                rx_valid,
	input  wire logic [BYTE_W-1:0]   rx_data,
	output logic                     tx_valid,
	output logic      [BYTE_W-1:0]   tx_data,
	input  wire logic                tx_ready,
	output ffdd_word_type            fir_coef,
	output ffdd_word_type            fir_in,
	input  wire logic                fir_in_ready,
	input  wire ffdd_word_type       fir_out,
	output logic                     fir_out_ready,
	output ffdd_word_type            fft_in,
	input  wire logic                fft_in_ready,
	input  wire ffdd_spec_type       fft_out,
	output logic                     filter_done
);
	localparam int IW = $clog2(POINTS);
	localparam logic [IW-1:0] COEF_LAST  = IW'(TAPS - 1);
	localparam logic [IW-1:0] POINT_LAST = IW'(POINTS - 1);

	// ----------------------------------------------------------------
	// fabric reset
	// ----------------------------------------------------------------
	logic       arst_n;
	logic [1:0] rst_pipe_q;
	logic       frst_n;

	assign arst_n = rst_n && init_done && pll_locked;
	assign frst_n = rst_pipe_q[1];

	// assert at once, release two ce-enabled edges later in the clock domain
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_pipe_q <= RST_PIPE_INIT;
		end else if (ce) begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// buffers
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] coef_mem [POINTS];
	logic [WORD_W-1:0] samp_mem [POINTS];
	logic [WORD_W-1:0] res_mem  [POINTS];
	logic [WORD_W-1:0] re_mem   [POINTS];
	logic [WORD_W-1:0] im_mem   [POINTS];

	ffdd_link_type     link_q;
	ffdd_seq_type      seq_q;
	logic [BYTE_W-1:0] rx_hi_q;
	logic              rx_ph_q;
	logic [IW-1:0]     widx_q;
	logic [IW-1:0]     tx_idx_q;
	logic              tx_ph_q;
	logic              run_start_q;
	logic              run_done_q;
	logic [IW-1:0]     sidx_q;
	logic [IW-1:0]     oidx_q;
	logic [IW-1:0]     spec_idx_q;
	logic              coef_wr;
	logic              samp_wr;
	logic              fir_acc;
	logic              tx_req;
	logic [BYTE_W-1:0] tx_byte;
	logic              buf_ready;
	logic              tx_push;
	logic [WORD_W-1:0] tx_word;

	assign coef_wr = (link_q == LINK_RX_COEF) && rx_valid && rx_ph_q;
	assign samp_wr = (link_q == LINK_RX_SAMP) && rx_valid && rx_ph_q;
	assign fir_acc = fir_out.valid && fir_out_ready;

	always_ff @(posedge clock) begin
		if (ce) begin
			if (coef_wr) begin
				coef_mem[widx_q] <= {rx_hi_q, rx_data};
			end
			if (samp_wr) begin
				samp_mem[widx_q] <= {rx_hi_q, rx_data};
			end
			if (fir_acc) begin
				res_mem[oidx_q] <= fir_out.data;
			end
			if (fft_out.valid) begin
				re_mem[spec_idx_q] <= fft_out.re;
				im_mem[spec_idx_q] <= fft_out.im;
			end
		end
	end

	// ----------------------------------------------------------------
	// host link
	// ----------------------------------------------------------------
	always_comb begin
		unique case (link_q)
			LINK_TX_FIR: tx_word = res_mem[tx_idx_q];
			LINK_TX_RE:  tx_word = re_mem[tx_idx_q];
			default:     tx_word = im_mem[tx_idx_q];
		endcase
	end

	always_comb begin
		tx_req  = 1'b1;
		tx_byte = tx_ph_q ? tx_word[7:0] : tx_word[15:8];
		unique case (link_q)
			LINK_SEND_ACK:   tx_byte = CHAR_ACK;
			LINK_SEND_HAND:  tx_byte = CHAR_HAND;
			LINK_SEND_AGREE: tx_byte = CHAR_AGREE;
			LINK_SEND_READY: tx_byte = CHAR_READY;
			LINK_TX_FIR, LINK_TX_RE, LINK_TX_IM: tx_req = 1'b1;
			default:         tx_req = 1'b0;
		endcase
	end

	assign tx_push = tx_req && buf_ready;

	// a stalled transmitter backs up here and stops the link machine
	ffdd_tx_buffer #(
		.WIDTH (BYTE_W),
		.DEPTH (TXBUF_DEPTH)
	) u_tx_buffer (
		.clock     (clock),
		.rst_n     (frst_n),
		.ce        (ce),
		.in_valid  (tx_req),
		.in_data   (tx_byte),
		.in_ready  (buf_ready),
		.out_valid (tx_valid),
		.out_data  (tx_data),
		.out_ready (tx_ready)
	);

	always_ff @(posedge clock or negedge frst_n) begin
		if (!frst_n) begin
			link_q      <= LINK_WAIT_SYNC;
			rx_hi_q     <= '0;
			rx_ph_q     <= 1'b0;
			widx_q      <= '0;
			tx_idx_q    <= '0;
			tx_ph_q     <= 1'b0;
			run_start_q <= 1'b0;
		end else if (ce) begin
			run_start_q <= 1'b0;
			unique case (link_q)
				LINK_WAIT_SYNC: begin
					// nothing else is accepted until the link is proven
					if (rx_valid && rx_data == CHAR_SYNC) begin
						link_q <= LINK_SEND_ACK;
					end
				end
				LINK_SEND_ACK: begin
					if (tx_push) begin
						link_q <= LINK_SEND_HAND;
					end
				end
				LINK_SEND_HAND: begin
					if (tx_push) begin
						link_q <= LINK_SEND_AGREE;
					end
				end
				LINK_SEND_AGREE: begin
					if (tx_push) begin
						link_q  <= LINK_RX_COEF;
						widx_q  <= '0;
						rx_ph_q <= 1'b0;
					end
				end
				LINK_RX_COEF, LINK_RX_SAMP: begin
					if (rx_valid) begin
						rx_ph_q <= ~rx_ph_q;
						if (!rx_ph_q) begin
							rx_hi_q <= rx_data;
						end else if (link_q == LINK_RX_COEF && widx_q == COEF_LAST) begin
							widx_q <= '0;
							link_q <= LINK_SEND_READY;
						end else if (link_q == LINK_RX_SAMP && widx_q == POINT_LAST) begin
							widx_q      <= '0;
							link_q      <= LINK_RUN;
							run_start_q <= 1'b1;
						end else begin
							widx_q <= IW'(widx_q + 1'b1);
						end
					end
				end
				LINK_SEND_READY: begin
					if (tx_push) begin
						link_q <= LINK_RX_SAMP;
					end
				end
				LINK_RUN: begin
					if (run_done_q) begin
						link_q   <= LINK_TX_FIR;
						tx_idx_q <= '0;
						tx_ph_q  <= 1'b0;
					end
				end
				LINK_TX_FIR, LINK_TX_RE, LINK_TX_IM: begin
					if (tx_push) begin
						tx_ph_q <= ~tx_ph_q;
						if (tx_ph_q) begin
							tx_idx_q <= IW'(tx_idx_q + 1'b1);
							if (tx_idx_q == POINT_LAST) begin
								tx_idx_q <= '0;
								unique case (link_q)
									LINK_TX_FIR: link_q <= LINK_TX_RE;
									LINK_TX_RE:  link_q <= LINK_TX_IM;
									default:     link_q <= LINK_WAIT_SYNC;
								endcase
							end
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// filter sequencer
	// ----------------------------------------------------------------
	assign fir_out_ready = !fft_in.valid || fft_in_ready;

	always_ff @(posedge clock or negedge frst_n) begin
		if (!frst_n) begin
			seq_q       <= SEQ_IDLE;
			sidx_q      <= '0;
			fir_coef    <= '0;
			fir_in      <= '0;
			run_done_q  <= 1'b0;
			filter_done <= 1'b0;
		end else if (ce) begin
			run_done_q     <= 1'b0;
			fir_coef.valid <= 1'b0;
			if (fir_in.valid && fir_in_ready) begin
				fir_in.valid <= 1'b0;
			end
			unique case (seq_q)
				SEQ_IDLE: begin
					if (run_start_q) begin
						seq_q       <= SEQ_COEF;
						sidx_q      <= '0;
						filter_done <= 1'b0;
					end
				end
				SEQ_COEF: begin
					// a fresh set per run sets the response type
					fir_coef <= '{valid: 1'b1, first: sidx_q == '0,
						data: coef_mem[sidx_q]};
					sidx_q <= (sidx_q == COEF_LAST) ? '0 : IW'(sidx_q + 1'b1);
					if (sidx_q == COEF_LAST) begin
						seq_q <= SEQ_DATA;
					end
				end
				SEQ_DATA: begin
					if (!fir_in.valid || fir_in_ready) begin
						fir_in <= '{valid: 1'b1, first: sidx_q == '0,
							data: samp_mem[sidx_q]};
						sidx_q <= IW'(sidx_q + 1'b1);
						if (sidx_q == POINT_LAST) begin
							seq_q <= SEQ_DRAIN;
						end
					end
				end
				SEQ_DRAIN: begin
					if (fft_out.valid && spec_idx_q == POINT_LAST) begin
						seq_q       <= SEQ_IDLE;
						run_done_q  <= 1'b1;
						filter_done <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge frst_n) begin
		if (!frst_n) begin
			fft_in     <= '0;
			oidx_q     <= '0;
			spec_idx_q <= '0;
		end else if (ce) begin
			if (fft_in.valid && fft_in_ready) begin
				fft_in.valid <= 1'b0;
			end
			if (run_start_q) begin
				oidx_q     <= '0;
				spec_idx_q <= '0;
			end else begin
				if (fir_acc) begin
					// filter output feeds the fft frame in order
					fft_in <= '{valid: 1'b1, first: oidx_q == '0, data: fir_out.data};
					oidx_q <= IW'(oidx_q + 1'b1);
				end
				if (fft_out.valid) begin
					spec_idx_q <= IW'(spec_idx_q + 1'b1);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!frst_n);

	chk_sync_answer: assert property (ce && link_q == LINK_WAIT_SYNC && rx_valid
		&& rx_data == CHAR_SYNC |=> link_q == LINK_SEND_ACK)
		else $error("sync character not answered");
	chk_ack_sequence: assert property (link_q == LINK_SEND_ACK && tx_push && ce
		|-> tx_byte == CHAR_ACK ##1 link_q == LINK_SEND_HAND)
		else $error("acknowledge sequence broken");
	chk_coef_after_hs: assert property ($changed(link_q) && link_q == LINK_RX_COEF
		|-> $past(link_q) == LINK_SEND_AGREE)
		else $error("coefficients accepted without handshake");
	chk_word_pack: assert property (ce && coef_wr
		|=> coef_mem[$past(widx_q)] == {$past(rx_hi_q), $past(rx_data)})
		else $error("coefficient word packed wrongly");
	chk_ready_char: assert property (link_q == LINK_SEND_READY && tx_push
		|-> tx_byte == CHAR_READY)
		else $error("ready character wrong");
	chk_coef_first: assert property ($rose(fir_coef.valid)
		|-> fir_coef.first && fir_coef.data == coef_mem[0])
		else $error("coefficient reload not from first entry");
	chk_result_store: assert property (ce && fir_acc
		|=> res_mem[$past(oidx_q)] == $past(fir_out.data))
		else $error("filter output not stored");
	chk_spec_store: assert property (ce && fft_out.valid
		|=> re_mem[$past(spec_idx_q)] == $past(fft_out.re)
		&& im_mem[$past(spec_idx_q)] == $past(fft_out.im))
		else $error("spectrum not stored");
	chk_tx_msb: assert property (ce && tx_push && link_q == LINK_TX_FIR && !tx_ph_q
		|-> tx_byte == res_mem[tx_idx_q][15:8])
		else $error("result high byte not sent first");
	chk_reset_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!pll_locked |=> !frst_n)
		else $error("fabric reset released without pll lock");

	cov_handshake: cover property (link_q == LINK_SEND_AGREE ##1 link_q == LINK_RX_COEF);
	cov_run_done: cover property (run_done_q);
	cov_tx_stall: cover property (tx_req && !buf_ready);
	cov_frame_out: cover property (link_q == LINK_TX_IM ##1 link_q == LINK_WAIT_SYNC);

endmodule
`default_nettype wire

// *** sim/ffdd_host_model.sv ***
// host side of the serial link: sends bytes and collects what the device transmits
`timescale 1ns/10ps
`default_nettype none
module ffdd_host_model
	import ffdd_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              stall,
	output logic                   rx_valid,
	output logic      [BYTE_W-1:0] rx_data,
	input  wire logic              tx_valid,
	input  wire logic [BYTE_W-1:0] tx_data,
	output logic                   tx_ready
);
	logic [BYTE_W-1:0] got[$];
	logic [1:0]        beat;

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
		beat = 2'h0;
	end

	// ----------------------------------------------------------------
	// receiver: a slow host drops ready every fourth cycle
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		beat = beat + 2'h1;
		#1 tx_ready = !(stall && beat == 2'h0);
	end

	// ----------------------------------------------------------------
	// sender
	// ----------------------------------------------------------------
	task automatic send_byte(input logic [BYTE_W-1:0] b);
		@(posedge clock);
		#1 rx_valid = 1'b1;
		rx_data = b;
		@(posedge clock);
		#1 rx_valid = 1'b0;
		rx_data = ~b; // released line must not look like the last byte
	endtask

	task automatic send_word(input logic [WORD_W-1:0] w);
		send_byte(w[15:8]);
		send_byte(w[7:0]);
	endtask

	// the host moves on once the expected character is the newest one seen, or after 400 cycles without it
	task automatic wait_for(input logic [BYTE_W-1:0] c, output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 400 && !seen; i++) begin
			@(posedge clock);
			seen = got.size() > 0 && got[got.size()-1] === c;
		end
	endtask
endmodule
`default_nettype wire

// *** sim/ffdd_datapath_bench.sv ***
// self-checking bench of the filter demo datapath with filter and fft stand-ins
`timescale 1ns/10ps
`default_nettype none
module ffdd_datapath_bench
	import ffdd_pkg::*;
;
	localparam int TAPS   = 3;
	localparam int POINTS = 4;
	typedef struct packed {
		logic [WORD_W-1:0] samp;
		logic [WORD_W-1:0] res;
	} ffdd_row_type;

	logic              clock, rst_n, ce, init_done, pll_locked, stall, seen;
	logic              rx_valid, tx_valid, tx_ready, fir_in_ready, fft_in_ready;
	logic              fir_out_ready, filter_done;
	logic [BYTE_W-1:0] rx_data, tx_data;
	logic [BYTE_W-1:0] exp_q[$];
	logic [WORD_W-1:0] fq[$];
	ffdd_word_type     fir_coef, fir_in, fir_out, fft_in;
	ffdd_spec_type     fft_out;
	int                errors, compares, coef_n, samp_n, fo_n, out_n, bin_n, cyc, got_n;
	logic [WORD_W-1:0] coefs[TAPS] = '{16'h1234, 16'hfe01, 16'h00ff};
	ffdd_row_type      rows[POINTS] = '{'{16'h8001, 16'h8102}, '{16'h00ff, 16'h0200},
		'{16'hffff, 16'h0100}, '{16'h7f80, 16'h8081}};

	ffdd_datapath #(.TAPS(TAPS), .POINTS(POINTS), .TXBUF_DEPTH(2)) ffdd_datapath_i (
		.clock(clock), .rst_n(rst_n), .ce(ce), .init_done(init_done),
		.pll_locked(pll_locked), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.fir_coef(fir_coef), .fir_in(fir_in), .fir_in_ready(fir_in_ready),
		.fir_out(fir_out), .fir_out_ready(fir_out_ready), .fft_in(fft_in),
		.fft_in_ready(fft_in_ready), .fft_out(fft_out), .filter_done(filter_done));

	ffdd_host_model ffdd_host_model_i (.clock(clock), .stall(stall), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	// ----------------------------------------------------------------
	// compare and closing tasks
	// ----------------------------------------------------------------
	task automatic check_word(input string what, input logic [WORD_W-1:0] e,
		input logic [WORD_W-1:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic check_bit(input string what, input logic e, input logic g);
		check_word(what, {15'h0000, e}, {15'h0000, g});
	endtask

	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// filter and fft stand-ins, both stalling now and then
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		cyc++;
		if (fir_coef.valid === 1'b1) begin
			check_word("coef", coefs[coef_n], fir_coef.data);
			check_bit("coef first", coef_n == 0, fir_coef.first);
			coef_n++;
		end else if (coef_n > 0 && coef_n < TAPS)
			check_bit("coef burst", 1'b1, 1'b0);
		if (fir_in.valid === 1'b1 && fir_in_ready) begin
			check_word("sample", rows[samp_n].samp, fir_in.data);
			check_bit("coef before sample", 1'b1, coef_n == TAPS);
			fq.push_back(rows[samp_n].res);
			samp_n++;
		end
		if (fir_out.valid && fir_out_ready === 1'b1) begin
			void'(fq.pop_front());
			fo_n++;
		end
		if (fft_in.valid === 1'b1 && fft_in_ready) begin
			check_word("fft feed", rows[out_n].res, fft_in.data);
			check_bit("fft first", out_n == 0, fft_in.first);
			out_n++;
		end
		#1;
		fir_in_ready = cyc % 3 != 0;
		fft_in_ready = cyc % 4 != 1;
		fir_out.valid = fq.size() > 0;
		fir_out.first = fo_n == 0;
		fir_out.data = fq.size() > 0 ? fq[0] : ~fir_out.data;
		fft_out.valid = out_n == POINTS && bin_n < POINTS;
		fft_out.re = fft_out.valid ? 16'(16'ha000 + bin_n) : ~fft_out.re;
		fft_out.im = fft_out.valid ? 16'(16'h5000 + bin_n) : ~fft_out.im;
		if (fft_out.valid)
			bin_n++;
	end

	initial begin
		#100000;
		errors++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		init_done = 1'b1;
		pll_locked = 1'b1;
		stall = 1'b1;
		fir_in_ready = 1'b0;
		fft_in_ready = 1'b0;
		fir_out = '0;
		fft_out = '0;
		repeat (10) @(posedge clock);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clock);
		ffdd_host_model_i.send_byte(CHAR_AGREE);
		ffdd_host_model_i.send_byte(CHAR_SYNC);
		ffdd_host_model_i.wait_for(CHAR_AGREE, seen);
		check_bit("handshake", 1'b1, seen);
		foreach (coefs[i])
			ffdd_host_model_i.send_word(coefs[i]);
		ffdd_host_model_i.wait_for(CHAR_READY, seen);
		check_bit("ready char", 1'b1, seen);
		exp_q = '{CHAR_ACK, CHAR_HAND, CHAR_AGREE, CHAR_READY};
		foreach (rows[i]) begin
			ffdd_host_model_i.send_word(rows[i].samp);
			exp_q.push_back(rows[i].res[15:8]);
			exp_q.push_back(rows[i].res[7:0]);
		end
		// spectrum stand-in gives bin k as a000+k real and 5000+k imaginary
		for (int j = 0; j < POINTS; j++) begin
			exp_q.push_back(8'ha0);
			exp_q.push_back(8'(j));
		end
		for (int j = 0; j < POINTS; j++) begin
			exp_q.push_back(8'h50);
			exp_q.push_back(8'(j));
		end
		for (int i = 0; i < 3000 && ffdd_host_model_i.got.size() < exp_q.size(); i++)
			@(posedge clock);
		check_bit("filter done", 1'b1, filter_done);
		check_word("tx count", 16'(exp_q.size()), 16'(ffdd_host_model_i.got.size()));
		foreach (exp_q[i]) begin
			if (i < ffdd_host_model_i.got.size())
				check_word("tx byte", {8'h00, exp_q[i]}, {8'h00, ffdd_host_model_i.got[i]});
		end
		// lock loss is held across an edge so the reset hold check sees it
		@(posedge clock);
		#1 pll_locked = 1'b0;
		@(posedge clock);
		#1 check_bit("done on lock loss", 1'b0, filter_done);
		pll_locked = 1'b1;
		init_done = 1'b0;
		@(posedge clock);
		#1 check_bit("idle tx in reset", 1'b0, tx_valid);
		check_bit("out ready in reset", 1'b1, fir_out_ready);
		init_done = 1'b1;
		rst_n = 1'b0;
		ce = 1'b0;
		@(posedge clock);
		#1 check_bit("coef idle in reset", 1'b0, fir_coef.valid);
		rst_n = 1'b1;
		// with the enable low the reset release must stay frozen
		got_n = ffdd_host_model_i.got.size();
		ffdd_host_model_i.send_byte(CHAR_SYNC);
		repeat (5) @(posedge clock);
		check_word("ce freeze", 16'(got_n), 16'(ffdd_host_model_i.got.size()));
		check_bit("tx idle while frozen", 1'b0, tx_valid);
		#1 ce = 1'b1;
		repeat (3) @(posedge clock);
		ffdd_host_model_i.send_byte(CHAR_SYNC);
		ffdd_host_model_i.wait_for(CHAR_AGREE, seen);
		check_bit("link after reset", 1'b1, seen);
		report_and_stop();
	end
endmodule
`default_nettype wire
